// *** fpla_prog_pkg.sv ***
// Package with constants and carrier types for the array programmer
package fpla_prog_pkg;
    localparam int unsigned N_INPUTS = 16;
    localparam int unsigned N_OUTPUTS = 8;
    localparam int unsigned N_TERMS = 48;
    localparam int unsigned TERM_BITS = 6;
    localparam int unsigned INPUT_BITS = 4;
    localparam int unsigned OUTPUT_BITS = 3;
    // Timing in its own units and the clock rate
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned FUSE_PULSE_MS = 1;
    localparam int unsigned POLARITY_PULSE_MS = 1;
    // Least times round up to whole cycles
    localparam int unsigned SETTLE_CYC =
        (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FUSE_PULSE_CYC =
        (FUSE_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POLARITY_PULSE_CYC =
        (POLARITY_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_BITS = 16;

    // Per-input treatment within one product term
    typedef enum logic [1:0] {
        LIT_DONT_CARE = 2'h0,
        LIT_TRUE = 2'h1,
        LIT_COMPLEMENT = 2'h2,
        LIT_UNTOUCHED = 2'h3
    } literal_type;

    // Programmer command: one product term or one polarity
    typedef struct packed {
        logic polarity;
        logic [OUTPUT_BITS-1:0] out_sel;
        logic [TERM_BITS-1:0] term;
        logic [2*N_INPUTS-1:0] literals;
    } cmd_type;

    // Pin drive towards the array
    typedef struct packed {
        logic [N_INPUTS-1:0] in_level;
        logic [N_INPUTS-1:0] in_disable;
        logic [N_OUTPUTS-1:0] out_level;
        logic [N_OUTPUTS-1:0] out_oe;
        logic [N_OUTPUTS-1:0] out_prog;
        logic chip_en_n;
        logic fuse_program_pin;
        logic power_on;
    } pins_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_POL_PULSE = 4'h1,
        ST_TERM_SETUP = 4'h2,
        ST_LIT_SETUP = 4'h3,
        ST_FUSE_RAISE = 4'h4,
        ST_CE_PULSE = 4'h5,
        ST_FUSE_HOLD = 4'h6,
        ST_LIT_RETURN = 4'h7,
        ST_VERIFY = 4'h8
    } state_type;
endpackage

// *** fpla_programmer.sv ***
// Programmer that sets output polarity and fuses product-matrix links
`timescale 1ns/1ps
module fpla_programmer #(
    parameter int unsigned FUSE_CYC = fpla_prog_pkg::FUSE_PULSE_CYC,
    parameter int unsigned POL_CYC = fpla_prog_pkg::POLARITY_PULSE_CYC,
    parameter int unsigned SETTLE = fpla_prog_pkg::SETTLE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input wire fpla_prog_pkg::cmd_type cmd_i,
    input wire logic verify_i,
    input wire logic [fpla_prog_pkg::N_OUTPUTS-1:0] out_sense_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic polarity_error_o,
    output logic [fpla_prog_pkg::N_OUTPUTS-1:0] polarity_o,
    output fpla_prog_pkg::pins_type pins_o
);
    // Whole state in one struct so reset and next state stay in step
    typedef struct packed {
        fpla_prog_pkg::state_type st;
        fpla_prog_pkg::cmd_type cmd;
        logic [fpla_prog_pkg::INPUT_BITS-1:0] idx;
        logic second;
        logic [fpla_prog_pkg::CNT_BITS-1:0] cnt;
        logic ready;
        logic done;
        logic pol_err;
        logic [fpla_prog_pkg::N_OUTPUTS-1:0] pol_seen;
        logic [fpla_prog_pkg::N_OUTPUTS-1:0] polarity;
        logic matrix_started;
        logic [1:0] verify_wait;
        logic [fpla_prog_pkg::N_OUTPUTS-1:0] sense_meta;
        logic [fpla_prog_pkg::N_OUTPUTS-1:0] sense;
        fpla_prog_pkg::pins_type pins;
    } regs_type;

    regs_type s_q;
    regs_type s_d;
    fpla_prog_pkg::literal_type lit;

    // Treatment of the input now being worked on
    always_comb begin
        lit = fpla_prog_pkg::literal_type'(s_q.cmd.literals[
            {s_q.idx, 1'b0} +: 2]);
    end

    // Sequencer for polarity, product-matrix and polarity verify steps
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // Sense pins come from the array: two stages, and only the
        // second is read, so a changing level cannot split decisions
        s_d.sense_meta = out_sense_i;
        s_d.sense = s_q.sense_meta;
        case (s_q.st)
            fpla_prog_pkg::ST_IDLE: begin
                s_d.ready = 1'b1;
                s_d.pins.power_on = 1'b1;
                s_d.pins.out_oe = 8'h00;
                s_d.pins.out_prog = 8'h00;
                s_d.pins.chip_en_n = 1'b1;
                s_d.pins.in_disable = 16'hffff;
                if (verify_i && s_q.ready) begin
                    s_d.ready = 1'b0;
                    s_d.pins.chip_en_n = 1'b0;
                    s_d.cnt = 16'h0000;
                    s_d.st = fpla_prog_pkg::ST_VERIFY;
                end else if (cmd_valid_i && s_q.ready) begin
                    s_d.ready = 1'b0;
                    s_d.cmd = cmd_i;
                    s_d.cnt = 16'h0000;
                    s_d.idx = 4'h0;
                    s_d.second = 1'b0;
                    if (cmd_i.polarity) begin
                        // Polarity after matrix work is refused
                        if (s_q.matrix_started ||
                            s_q.pol_seen[cmd_i.out_sel]) begin
                            s_d.pol_err = 1'b1;
                            s_d.done = 1'b1;
                        end else begin
                            s_d.pins.power_on = 1'b0;
                            s_d.pins.out_prog[cmd_i.out_sel] = 1'b1;
                            s_d.st = fpla_prog_pkg::ST_POL_PULSE;
                        end
                    end else begin
                        s_d.matrix_started = 1'b1;
                        s_d.st = fpla_prog_pkg::ST_TERM_SETUP;
                    end
                end
            end
            fpla_prog_pkg::ST_POL_PULSE: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (32'(s_q.cnt) + 1 >= POL_CYC) begin
                    s_d.pins.out_prog = 8'h00;
                    s_d.pol_seen[s_q.cmd.out_sel] = 1'b1;
                    s_d.polarity[s_q.cmd.out_sel] = 1'b1;
                    s_d.done = 1'b1;
                    s_d.st = fpla_prog_pkg::ST_IDLE;
                end
            end
            fpla_prog_pkg::ST_TERM_SETUP: begin
                // Term number on the six low outputs, disabled chip
                s_d.pins.chip_en_n = 1'b1;
                s_d.pins.in_disable = 16'hffff;
                s_d.pins.out_oe = 8'h3f;
                s_d.pins.out_level = {2'b00, s_q.cmd.term};
                s_d.st = fpla_prog_pkg::ST_LIT_SETUP;
            end
            fpla_prog_pkg::ST_LIT_SETUP: begin
                // Untouched inputs are skipped; don't-care fuses both
                if (lit == fpla_prog_pkg::LIT_UNTOUCHED) begin
                    s_d.st = fpla_prog_pkg::ST_LIT_RETURN;
                end else begin
                    s_d.pins.in_disable[s_q.idx] = 1'b0;
                    s_d.pins.in_level[s_q.idx] =
                        (lit == fpla_prog_pkg::LIT_TRUE) ||
                        (lit == fpla_prog_pkg::LIT_DONT_CARE &&
                         !s_q.second);
                    s_d.cnt = 16'h0000;
                    s_d.st = fpla_prog_pkg::ST_FUSE_RAISE;
                end
            end
            fpla_prog_pkg::ST_FUSE_RAISE: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (32'(s_q.cnt) + 1 >= SETTLE) begin
                    s_d.pins.fuse_program_pin = 1'b1;
                    s_d.cnt = 16'h0000;
                    s_d.st = fpla_prog_pkg::ST_CE_PULSE;
                end
            end
            fpla_prog_pkg::ST_CE_PULSE: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                // Enable sits high before and after its programming pulse
                if (32'(s_q.cnt) + 1 == SETTLE) begin
                    s_d.pins.chip_en_n = 1'b0;
                end
                if (32'(s_q.cnt) + 1 >= SETTLE + FUSE_CYC) begin
                    s_d.pins.chip_en_n = 1'b1;
                    s_d.cnt = 16'h0000;
                    s_d.st = fpla_prog_pkg::ST_FUSE_HOLD;
                end
            end
            fpla_prog_pkg::ST_FUSE_HOLD: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (32'(s_q.cnt) + 1 >= SETTLE) begin
                    s_d.pins.fuse_program_pin = 1'b0;
                    if (lit == fpla_prog_pkg::LIT_DONT_CARE &&
                        !s_q.second) begin
                        s_d.second = 1'b1;
                        s_d.st = fpla_prog_pkg::ST_LIT_SETUP;
                    end else begin
                        s_d.st = fpla_prog_pkg::ST_LIT_RETURN;
                    end
                end
            end
            fpla_prog_pkg::ST_LIT_RETURN: begin
                s_d.pins.in_disable[s_q.idx] = 1'b1;
                s_d.second = 1'b0;
                s_d.idx = s_q.idx + 4'h1;
                // Last input done: stop driving the term number
                if (s_q.idx == 4'hf) begin
                    s_d.pins.out_oe = 8'h00;
                    s_d.done = 1'b1;
                    s_d.st = fpla_prog_pkg::ST_IDLE;
                end else begin
                    s_d.st = fpla_prog_pkg::ST_LIT_SETUP;
                end
            end
            fpla_prog_pkg::ST_VERIFY: begin
                // Wait out the sense synchroniser before reading
                s_d.verify_wait = s_q.verify_wait + 2'h1;
                if (s_q.verify_wait == 2'h3) begin
                    s_d.polarity = ~s_q.sense;
                    s_d.pins.chip_en_n = 1'b1;
                    s_d.verify_wait = 2'h0;
                    s_d.done = 1'b1;
                    s_d.st = fpla_prog_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.st = fpla_prog_pkg::ST_IDLE;
            end
        endcase
    end

    // State register; reset leaves every input at its disable level
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{st: fpla_prog_pkg::ST_IDLE,
                     pins: '{in_disable: 16'hffff, chip_en_n: 1'b1,
                             power_on: 1'b1, default: '0},
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the state register
    assign cmd_ready_o = s_q.ready;
    assign done_o = s_q.done;
    assign polarity_error_o = s_q.pol_err;
    assign polarity_o = s_q.polarity;
    assign pins_o = s_q.pins;
endmodule

// *** fpla_programmer_properties.sv ***
// Checker for the programmer pin sequences
`timescale 1ns/1ps
module fpla_programmer_properties #(
    parameter int unsigned FUSE_CYC = 20,
    parameter int unsigned POL_CYC = 20
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_ready_o,
    input wire logic done_o,
    input wire fpla_prog_pkg::pins_type pins_o
);
    logic [15:0] low_q;
    logic [15:0] prog_q;
    // Pulse lengths kept in counters, too long for a repetition
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_q <= 16'h0000;
            prog_q <= 16'h0000;
        end else begin
            low_q <= pins_o.chip_en_n ? 16'h0000 : low_q + 16'h0001;
            prog_q <= (|pins_o.out_prog) ? prog_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence fuse_lead;
        pins_o.chip_en_n [*4] ##[1:5] !pins_o.chip_en_n;
    endsequence
    sequence fuse_tail;
        pins_o.fuse_program_pin [*4] ##[1:5] !pins_o.fuse_program_pin;
    endsequence
    AST_FUSE_LEAD: assert property (
        $rose(pins_o.fuse_program_pin) |-> fuse_lead)
        else $error("enable pulse not after settle time");
    AST_FUSE_TAIL: assert property (
        $rose(pins_o.chip_en_n) && pins_o.fuse_program_pin |-> fuse_tail)
        else $error("fuse pin not lowered after settle time");
    AST_FUSE_WIDTH: assert property (
        pins_o.chip_en_n && pins_o.fuse_program_pin && low_q != 0
        |-> low_q == FUSE_CYC)
        else $error("enable pulse width wrong");
    AST_POL_WIDTH: assert property (
        !(|pins_o.out_prog) && prog_q != 0 |-> prog_q == POL_CYC)
        else $error("polarity pulse width wrong");
    AST_POL_UNPOWERED: assert property (
        |pins_o.out_prog |-> !pins_o.power_on)
        else $error("polarity level applied while powered");
    AST_POL_ONE: assert property (
        $onehot0(pins_o.out_prog))
        else $error("more than one output in polarity step");
    AST_ONE_INPUT: assert property (
        pins_o.fuse_program_pin |-> $onehot(~pins_o.in_disable))
        else $error("not exactly one input released while fusing");
    AST_TERM_OE: assert property (
        !pins_o.chip_en_n && pins_o.fuse_program_pin
        |-> pins_o.out_oe == 8'h3f)
        else $error("term number not driven on six outputs");
    AST_DONE_READY: assert property (
        done_o |=> !done_o ##0 cmd_ready_o)
        else $error("done not single or ready not back");
endmodule

// *** fpla_device_model.sv ***
// Behavioural model of the logic array as seen from its pins
`timescale 1ns/1ps
// Sixteen inputs, eight outputs, 48 terms; matrix fusing not modelled
module fpla_device_model (
    input wire logic ref_clk_i,
    input wire fpla_prog_pkg::pins_type pins_i,
    output logic [fpla_prog_pkg::N_OUTPUTS-1:0] sense_o
);
    logic [7:0] low_q = 8'h00;
    // Polarity link only blows with the part unpowered
    always @(posedge ref_clk_i) begin
        low_q <= low_q |
            (pins_i.power_on ? 8'h00 : pins_i.out_prog);
    end
    // Released outputs pulled high; blank terms never fire
    always_comb begin
        if (pins_i.chip_en_n) begin
            sense_o = 8'hff;
        end else if (&pins_i.in_disable) begin
            sense_o = ~low_q;
        end else begin
            sense_o = low_q;
        end
    end
endmodule

// *** fpla_programmer_tb.sv ***
// Testbench for the array programmer against the array model
`timescale 1ns/1ps
module fpla_programmer_tb;
    logic ref_clk_i;
    logic nrst_i;
    logic cmd_valid_i;
    logic verify_i;
    fpla_prog_pkg::cmd_type cmd_i;
    logic [7:0] sense;
    logic cmd_ready_o;
    logic done_o;
    logic polarity_error_o;
    logic [7:0] polarity_o;
    fpla_prog_pkg::pins_type pins_o;
    logic prev_ce;
    logic [23:0] fires[$];
    int fails;
    int total_checks;
    fpla_programmer #(.FUSE_CYC(20), .POL_CYC(20), .SETTLE(4))
        fpla_programmer_inst (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .verify_i(verify_i), .out_sense_i(sense),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o),
        .polarity_error_o(polarity_error_o), .polarity_o(polarity_o),
        .pins_o(pins_o));
    fpla_device_model fpla_device_model_inst (
        .ref_clk_i(ref_clk_i), .pins_i(pins_o), .sense_o(sense));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // Log pins at each fuse pulse start; verify pulses carry no fuse pin
    always @(posedge ref_clk_i) begin
        prev_ce <= pins_o.chip_en_n;
        if (prev_ce && !pins_o.chip_en_n && pins_o.fuse_program_pin) begin
            fires.push_back({~pins_o.in_disable[3:0],
                pins_o.in_level[3:0] & ~pins_o.in_disable[3:0],
                2'b00, pins_o.out_level[5:0], pins_o.out_oe});
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One request, held until taken, then wait for done
    task automatic run(input fpla_prog_pkg::cmd_type c, input logic v,
                       input logic ver);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        while (cmd_ready_o !== 1'b1) @(posedge ref_clk_i);
        cmd_i <= c;
        cmd_valid_i <= v;
        verify_i <= ver;
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        verify_i <= 1'b0;
        while (done_o !== 1'b1 && n < 1000) begin
            @(posedge ref_clk_i);
            n++;
        end
        check(n < 1000, 1'b1);
    endtask
    task automatic do_reset;
        nrst_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check({pins_o.in_disable, pins_o.chip_en_n, pins_o.power_on,
               cmd_ready_o}, {16'hffff, 3'h6});
        repeat (6) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
    endtask
    // Polarity step; a refused one must leave the pins alone
    task automatic pol(input logic [2:0] sel, input logic [7:0] exp_pol,
                       input logic err);
        fpla_prog_pkg::cmd_type c;
        c = '0;
        c.polarity = 1'b1;
        c.out_sel = sel;
        fork
            run(c, 1'b1, 1'b0);
            begin
                repeat (5) @(posedge ref_clk_i);
                check({pins_o.out_prog, pins_o.power_on},
                      {err ? 8'h00 : 8'h01 << sel, err});
            end
        join
        check(polarity_o, exp_pol);
        check(polarity_error_o, err);
    endtask
    // Polarity verify: enabled chip, disabled inputs, levels read back
    task automatic t_verify(input logic [7:0] exp_pol);
        fork
            run('0, 1'b0, 1'b1);
            begin
                repeat (4) @(posedge ref_clk_i);
                check({pins_o.chip_en_n, pins_o.in_disable},
                      17'h0ffff);
            end
        join
        check(polarity_o, exp_pol);
    endtask
    // Term 0x2d: input 0 ignored, 1 true, 2 complement, rest untouched
    task automatic t_term;
        fpla_prog_pkg::cmd_type c;
        logic [23:0] exp_f[4];
        exp_f = '{24'h112d3f, 24'h102d3f, 24'h222d3f, 24'h402d3f};
        c = '0;
        c.term = 6'h2d;
        c.literals = 32'hffffffe4;
        fires.delete();
        run(c, 1'b1, 1'b0);
        check(24'(fires.size()), 24'h000004);
        for (int i = 0; i < 4; i++) begin
            check(fires[i], exp_f[i]);
        end
    endtask
    initial begin
        #500000;
        fails++;
        end_sim;
    end
    initial begin
        fails = 0;
        total_checks = 0;
        prev_ce = 1'b1;
        cmd_valid_i = 1'b0;
        verify_i = 1'b0;
        cmd_i = '0;
        nrst_i = 1'b0;
        do_reset;
        pol(3'h2, 8'h04, 1'b0);
        pol(3'h5, 8'h24, 1'b0);
        t_verify(8'h24);
        t_term;
        pol(3'h0, 8'h24, 1'b1);
        do_reset;
        pol(3'h3, 8'h08, 1'b0);
        pol(3'h3, 8'h08, 1'b1);
        end_sim;
    end
endmodule
bind fpla_programmer fpla_programmer_properties #(
    .FUSE_CYC(FUSE_CYC), .POL_CYC(POL_CYC)) fpla_programmer_properties_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .pins_o(pins_o));
